// File: hdl/acrb_defs.vh
`ifndef ACRB_DEFS_VH
`define ACRB_DEFS_VH

// Register addresses on the serial control port (6-bit).
`define ACRB_ADDR_POWER_SAMPLING   6'h01
`define ACRB_ADDR_OUTPUT_REFERENCE 6'h02
`define ACRB_ADDR_CLAMP_LEVEL      6'h03
`define ACRB_ADDR_SOFT_RESET       6'h04
`define ACRB_ADDR_CLAMP_COLOUR     6'h06
`define ACRB_ADDR_REVISION         6'h07
`define ACRB_ADDR_PULSE_DETECT     6'h08
`define ACRB_ADDR_TEST_CONTROL     6'h09
`define ACRB_ADDR_RESERVED_A       6'h0a
`define ACRB_ADDR_RESERVED_B       6'h0b
`define ACRB_ADDR_RESERVED_C       6'h0c
`define ACRB_ADDR_DAC_RED          6'h20
`define ACRB_ADDR_DAC_GREEN        6'h21
`define ACRB_ADDR_DAC_BLUE         6'h22
`define ACRB_ADDR_DAC_ALL          6'h23
`define ACRB_ADDR_GAIN_RED         6'h28
`define ACRB_ADDR_GAIN_GREEN       6'h29
`define ACRB_ADDR_GAIN_BLUE        6'h2a
`define ACRB_ADDR_GAIN_ALL         6'h2b

// Reset values.
`define ACRB_RST_POWER_SAMPLING    8'h0f
`define ACRB_RST_OUTPUT_REFERENCE  8'h23
`define ACRB_RST_CLAMP_LEVEL       8'h1f
`define ACRB_RST_CLAMP_COLOUR      8'h05
`define ACRB_RST_PULSE_DETECT      8'h00
`define ACRB_RST_TEST_CONTROL      8'h00
`define ACRB_RST_DAC               8'h80
`define ACRB_RST_GAIN              8'h00

// Writable bit masks; bits outside a mask hold their fixed value.
`define ACRB_WMASK_POWER_SAMPLING   8'h73
`define ACRB_WMASK_OUTPUT_REFERENCE 8'hec
`define ACRB_WMASK_CLAMP_LEVEL      8'h3f
`define ACRB_WMASK_CLAMP_COLOUR     8'h38
`define ACRB_WMASK_PULSE_DETECT     8'h1f
`define ACRB_WMASK_TEST_CONTROL     8'h80

// Field positions.
`define ACRB_BIT_ENABLE            0
`define ACRB_BIT_DOUBLE_SAMPLING   1
`define ACRB_FLD_OFFSET_HI         5
`define ACRB_FLD_OFFSET_LO         4
`define ACRB_BIT_MAX_SPEED         6
`define ACRB_BIT_POLARITY_INVERT   2
`define ACRB_BIT_EXT_CLAMP_REF     3
`define ACRB_BIT_CLAMP_SPAN        5
`define ACRB_FLD_LATENCY_HI        7
`define ACRB_FLD_LATENCY_LO        6
`define ACRB_BIT_READ_SELECT       4

// Serial frame and converter clock timing.
`define ACRB_FRAME_BITS            14
`define ACRB_CONV_MCLK_NORMAL      2'h2
`define ACRB_CONV_MCLK_FAST        2'h3

`endif

// File: hdl/acrb_sync.v
`timescale 1ns/1ps
// Two-flop synchroniser for pins arriving from outside the mclk domain.
module acrb_sync #(
  parameter WIDTH = 3
) (
  input  wire             mclk,   // Master clock.
  input  wire             rst,    // Synchronous reset, active high.
  input  wire [WIDTH-1:0] async_in, // Pins from the outside world.
  output reg  [WIDTH-1:0] sync_out  // Synchronised copy.
);

  reg [WIDTH-1:0] meta;

  // The first stage feeds only the second stage.
  always @(posedge mclk) begin
    if (rst) begin
      meta     <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // acrb_sync

// File: hdl/acrb_reg_bank.v
// Operation
// - Control bits sit in addressed 8-bit registers.
// - Setup bit 0 powers whole device.
// - Setup bit 1 selects double sampling.
// - Bits 5:4 set zero-input output offset.
// - Second setup bit 2 inverts output polarity.
// - Bit 3 powers down clamp DAC, hi-Z.
// - Bit 5 selects clamp DAC span.
// - Bits 7:6 set extra output latency.
// - Converter period two mclks, three fast.
// - Latency codes add zero to three periods.
// - Address then data shifted MSB first.
// - Address bit 4 reads register back serially.
// - Write to address 0x04 resets registers.
`timescale 1ns/1ps
`include "acrb_defs.vh"
module acrb_reg_bank #(
  parameter [7:0] REVISION_CODE = 8'h5a  // Arbitrary value.
) (
  input  wire       mclk,                   // Master clock, 100 MHz.
  input  wire       rst,                    // Sync reset, active high.
  input  wire       sck,                    // Serial clock pin.
  input  wire       serial_data_in,         // Serial data pin.
  input  wire       serial_load_strobe,     // Load strobe pin.
  input  wire       fast_mode_select,       // High in the fast second mode.
  output reg        serial_data_out,        // Read-back data.
  output reg        serial_data_out_oe_n,   // Low while read-back drives.
  output wire       device_enable,          // High = fully active.
  output wire       double_sampling_select, // High = double sampling.
  output wire [1:0] zero_input_output_offset, // Offset code.
  output wire       max_speed_mode_flag,    // Max-speed mode flag.
  output wire       output_polarity_invert, // Invert output data.
  output wire       external_clamp_reference, // Clamp DAC off.
  output wire       clamp_reference_dac_en, // Clamp DAC powered.
  output wire       clamp_reference_pin_oe_n, // Low while DAC drives pin.
  output wire       clamp_dac_span,         // High = top reference span.
  output wire [1:0] output_latency,         // Latency code.
  output reg  [3:0] latency_mclk_count,     // Latency in mclk cycles.
  output reg        conv_clk_tick,          // Converter period pulse.
  output wire [7:0] clamp_level_timing,     // Third setup register.
  output wire [7:0] clamp_colour_select,    // Fourth setup register.
  output wire [7:0] sample_pulse_detect,    // Fifth setup register.
  output wire [7:0] test_control,           // Test register.
  output wire [7:0] offset_dac_red,         // Red offset.
  output wire [7:0] offset_dac_green,       // Green offset.
  output wire [7:0] offset_dac_blue,        // Blue offset.
  output wire [7:0] amp_gain_red,           // Red gain.
  output wire [7:0] amp_gain_green,         // Green gain.
  output wire [7:0] amp_gain_blue           // Blue gain.
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edge detection.

  wire [2:0] pins_sync;
  reg  [2:0] pins_last;
  wire       sck_s;
  wire       sdi_s;
  wire       sen_s;
  wire       sck_rise;
  wire       sck_fall;
  wire       sen_rise;

  acrb_sync #(
    .WIDTH (3)
  ) acrb_sync_inst (
    .mclk     (mclk),
    .rst      (rst),
    .async_in ({serial_load_strobe, serial_data_in, sck}),
    .sync_out (pins_sync)
  );

  assign sck_s    = pins_sync[0];
  assign sdi_s    = pins_sync[1];
  assign sen_s    = pins_sync[2];
  assign sck_rise = sck_s & ~pins_last[0];
  assign sck_fall = ~sck_s & pins_last[0];
  assign sen_rise = sen_s & ~pins_last[2];

  // Previous synchronised levels, for edge detection.
  always @(posedge mclk) begin
    if (rst) begin
      pins_last <= 3'h0;
    end else begin
      pins_last <= pins_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial input shifter: six address bits then eight data bits.

  reg  [13:0] frame;
  wire [5:0]  frame_addr;
  wire [7:0]  frame_data;
  wire        do_write;
  wire        do_read;

  assign frame_addr = frame[13:8];
  assign frame_data = frame[7:0];
  // A strobe after a frame commits it; the shifter keeps only the last bits.
  assign do_write = sen_rise & ~frame_addr[`ACRB_BIT_READ_SELECT];
  assign do_read  = sen_rise & frame_addr[`ACRB_BIT_READ_SELECT];

  // Each rising serial clock edge moves one bit in, MSB first.
  always @(posedge mclk) begin
    if (rst) begin
      frame <= 14'h0000;
    end else if (sck_rise) begin
      frame <= {frame[12:0], sdi_s};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.

  reg [7:0] power_sampling_config;
  reg [7:0] output_reference_config;
  reg [7:0] clamp_level_reg;
  reg [7:0] clamp_colour_reg;
  reg [7:0] pulse_detect_reg;
  reg [7:0] test_reg;
  reg [7:0] dac_red;
  reg [7:0] dac_green;
  reg [7:0] dac_blue;
  reg [7:0] gain_red;
  reg [7:0] gain_green;
  reg [7:0] gain_blue;

  wire soft_reset;

  assign soft_reset = do_write & (frame_addr == `ACRB_ADDR_SOFT_RESET);

  // Merge writable bits of new data with fixed bits of the reset value.
  function [7:0] merge_fixed;
    input [7:0] data;
    input [7:0] wmask;
    input [7:0] fixed;
    begin
      merge_fixed = (data & wmask) | (fixed & ~wmask);
    end
  endfunction

  // Register writes; hardware reset and soft reset both restore defaults.
  always @(posedge mclk) begin
    if (rst || soft_reset) begin
      power_sampling_config   <= `ACRB_RST_POWER_SAMPLING;
      output_reference_config <= `ACRB_RST_OUTPUT_REFERENCE;
      clamp_level_reg         <= `ACRB_RST_CLAMP_LEVEL;
      clamp_colour_reg        <= `ACRB_RST_CLAMP_COLOUR;
      pulse_detect_reg        <= `ACRB_RST_PULSE_DETECT;
      test_reg                <= `ACRB_RST_TEST_CONTROL;
      dac_red                 <= `ACRB_RST_DAC;
      dac_green               <= `ACRB_RST_DAC;
      dac_blue                <= `ACRB_RST_DAC;
      gain_red                <= `ACRB_RST_GAIN;
      gain_green              <= `ACRB_RST_GAIN;
      gain_blue               <= `ACRB_RST_GAIN;
    end else if (do_write) begin
      case (frame_addr)
        `ACRB_ADDR_POWER_SAMPLING: begin
          power_sampling_config <= merge_fixed(frame_data,
            `ACRB_WMASK_POWER_SAMPLING, `ACRB_RST_POWER_SAMPLING);
        end
        `ACRB_ADDR_OUTPUT_REFERENCE: begin
          output_reference_config <= merge_fixed(frame_data,
            `ACRB_WMASK_OUTPUT_REFERENCE, `ACRB_RST_OUTPUT_REFERENCE);
        end
        `ACRB_ADDR_CLAMP_LEVEL: begin
          clamp_level_reg <= merge_fixed(frame_data,
            `ACRB_WMASK_CLAMP_LEVEL, `ACRB_RST_CLAMP_LEVEL);
        end
        `ACRB_ADDR_CLAMP_COLOUR: begin
          clamp_colour_reg <= merge_fixed(frame_data,
            `ACRB_WMASK_CLAMP_COLOUR, `ACRB_RST_CLAMP_COLOUR);
        end
        `ACRB_ADDR_PULSE_DETECT: begin
          pulse_detect_reg <= merge_fixed(frame_data,
            `ACRB_WMASK_PULSE_DETECT, `ACRB_RST_PULSE_DETECT);
        end
        `ACRB_ADDR_TEST_CONTROL: begin
          test_reg <= merge_fixed(frame_data,
            `ACRB_WMASK_TEST_CONTROL, `ACRB_RST_TEST_CONTROL);
        end
        `ACRB_ADDR_DAC_RED: begin
          dac_red <= frame_data;
        end
        `ACRB_ADDR_DAC_GREEN: begin
          dac_green <= frame_data;
        end
        `ACRB_ADDR_DAC_BLUE: begin
          dac_blue <= frame_data;
        end
        `ACRB_ADDR_DAC_ALL: begin
          dac_red   <= frame_data;
          dac_green <= frame_data;
          dac_blue  <= frame_data;
        end
        `ACRB_ADDR_GAIN_RED: begin
          gain_red <= frame_data;
        end
        `ACRB_ADDR_GAIN_GREEN: begin
          gain_green <= frame_data;
        end
        `ACRB_ADDR_GAIN_BLUE: begin
          gain_blue <= frame_data;
        end
        `ACRB_ADDR_GAIN_ALL: begin
          gain_red   <= frame_data;
          gain_green <= frame_data;
          gain_blue  <= frame_data;
        end
        default: begin
          // Reserved, read-only and unmapped addresses keep no state.
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-back.

  // Read value of a register; combined, reserved and unmapped give zero.
  function [7:0] read_value;
    input [5:0] addr;
    begin
      case (addr)
        `ACRB_ADDR_POWER_SAMPLING:   read_value = power_sampling_config;
        `ACRB_ADDR_OUTPUT_REFERENCE: read_value = output_reference_config;
        `ACRB_ADDR_CLAMP_LEVEL:      read_value = clamp_level_reg;
        `ACRB_ADDR_CLAMP_COLOUR:     read_value = clamp_colour_reg;
        `ACRB_ADDR_REVISION:         read_value = REVISION_CODE;
        `ACRB_ADDR_PULSE_DETECT:     read_value = pulse_detect_reg;
        `ACRB_ADDR_TEST_CONTROL:     read_value = test_reg;
        `ACRB_ADDR_DAC_RED:          read_value = dac_red;
        `ACRB_ADDR_DAC_GREEN:        read_value = dac_green;
        `ACRB_ADDR_DAC_BLUE:         read_value = dac_blue;
        `ACRB_ADDR_GAIN_RED:         read_value = gain_red;
        `ACRB_ADDR_GAIN_GREEN:       read_value = gain_green;
        `ACRB_ADDR_GAIN_BLUE:        read_value = gain_blue;
        default:                     read_value = 8'h00;
      endcase
    end
  endfunction

  reg [7:0] read_shift;
  reg [3:0] read_left;

  // A read frame loads the register with bit 4 cleared; the MSB shows at
  // once and falling serial edges step through the rest. A new read strobe
  // restarts the shift, so overlapping frames are allowed.
  always @(posedge mclk) begin
    if (rst) begin
      read_shift           <= 8'h00;
      read_left            <= 4'h0;
      serial_data_out      <= 1'b0;
      serial_data_out_oe_n <= 1'b1;
    end else if (do_read) begin
      {serial_data_out, read_shift} <=
        {read_value(frame_addr & 6'h2f), 1'b0};
      read_left            <= 4'h8;
      serial_data_out_oe_n <= 1'b0;
    end else if (sck_fall && read_left != 4'h0) begin
      {serial_data_out, read_shift} <= {read_shift, 1'b0};
      read_left            <= read_left - 4'h1;
      serial_data_out_oe_n <= (read_left == 4'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control field decode.

  assign device_enable = power_sampling_config[`ACRB_BIT_ENABLE];
  assign double_sampling_select =
    power_sampling_config[`ACRB_BIT_DOUBLE_SAMPLING];
  // Codes 00 and 01 both give zero output; the analogue side decodes.
  assign zero_input_output_offset =
    power_sampling_config[`ACRB_FLD_OFFSET_HI:`ACRB_FLD_OFFSET_LO];
  // The controller alone keeps this consistent with the running mode.
  assign max_speed_mode_flag =
    power_sampling_config[`ACRB_BIT_MAX_SPEED];
  assign output_polarity_invert =
    output_reference_config[`ACRB_BIT_POLARITY_INVERT];
  assign external_clamp_reference =
    output_reference_config[`ACRB_BIT_EXT_CLAMP_REF];
  assign clamp_reference_dac_en   = ~external_clamp_reference;
  assign clamp_reference_pin_oe_n = external_clamp_reference;
  assign clamp_dac_span =
    output_reference_config[`ACRB_BIT_CLAMP_SPAN];
  assign output_latency =
    output_reference_config[`ACRB_FLD_LATENCY_HI:`ACRB_FLD_LATENCY_LO];

  assign clamp_level_timing  = clamp_level_reg;
  assign clamp_colour_select = clamp_colour_reg;
  assign sample_pulse_detect = pulse_detect_reg;
  assign test_control        = test_reg;
  assign offset_dac_red      = dac_red;
  assign offset_dac_green    = dac_green;
  assign offset_dac_blue     = dac_blue;
  assign amp_gain_red        = gain_red;
  assign amp_gain_green      = gain_green;
  assign amp_gain_blue       = gain_blue;

  ////////////////////////////////////////////////////////////////////////////
  // Converter clock period and latency in master clock cycles.

  wire [1:0] conv_period;
  reg  [1:0] conv_count;

  assign conv_period = fast_mode_select ? `ACRB_CONV_MCLK_FAST
                                        : `ACRB_CONV_MCLK_NORMAL;

  // Divider pulse once per converter period; idle while powered down.
  always @(posedge mclk) begin
    if (rst || !device_enable) begin
      conv_count    <= 2'h0;
      conv_clk_tick <= 1'b0;
    end else if (conv_count >= conv_period - 2'h1) begin
      conv_count    <= 2'h0;
      conv_clk_tick <= 1'b1;
    end else begin
      conv_count    <= conv_count + 2'h1;
      conv_clk_tick <= 1'b0;
    end
  end

  // Extra latency = code times the converter period (0 to 9 cycles).
  always @(posedge mclk) begin
    if (rst) begin
      latency_mclk_count <= 4'h0;
    end else begin
      latency_mclk_count <=
        {2'h0, output_latency} * {2'h0, conv_period};
    end
  end

endmodule // acrb_reg_bank

// File: verif/acrb_props.sv
`timescale 1ns/1ps
// Pin checks on the register bank, all on mclk and idle in reset.
module acrb_props (
  input wire       mclk,                     // Clock.
  input wire       rst,                      // Reset.
  input wire       sck,                      // Serial clock.
  input wire       serial_load_strobe,       // Strobe.
  input wire       fast_mode_select,         // Fast mode.
  input wire       serial_data_out,          // Read data.
  input wire       serial_data_out_oe_n,     // Read enable.
  input wire       device_enable,            // Enable.
  input wire       double_sampling_select,   // Sampling.
  input wire       external_clamp_reference, // DAC off.
  input wire       clamp_reference_dac_en,   // DAC on.
  input wire       clamp_reference_pin_oe_n, // Pin enable.
  input wire       clamp_dac_span,           // Span.
  input wire [1:0] output_latency,           // Latency.
  input wire [3:0] latency_mclk_count,       // Latency count.
  input wire       conv_clk_tick,            // Tick.
  input wire [7:0] offset_dac_red            // Red offset.
);
  wire [3:0] lat_exp;
  // Three master periods per converter period in fast mode, else two.
  assign lat_exp = fast_mode_select ?
    {2'h0, output_latency} + {1'h0, output_latency, 1'h0} :
    {1'h0, output_latency, 1'h0};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_reset_defaults: assert property (
    $fell(rst) |-> device_enable && double_sampling_select &&
    clamp_dac_span && output_latency == 2'h0)
    else $error("register defaults wrong after reset");
  a_clamp_pin_release: assert property (
    clamp_reference_pin_oe_n == external_clamp_reference &&
    clamp_reference_dac_en != external_clamp_reference)
    else $error("clamp DAC enables disagree");
  a_tick_normal_period: assert property (
    conv_clk_tick && !fast_mode_select && $stable(fast_mode_select) &&
    device_enable ##1 (!fast_mode_select && device_enable)[*2]
    |-> conv_clk_tick && !$past(conv_clk_tick))
    else $error("converter tick not every two cycles");
  a_tick_fast_period: assert property (
    conv_clk_tick && fast_mode_select && $stable(fast_mode_select) &&
    device_enable ##1 (fast_mode_select && device_enable)[*3]
    |-> conv_clk_tick && !$past(conv_clk_tick) && !$past(conv_clk_tick, 2))
    else $error("converter tick not every three cycles");
  a_tick_power_down: assert property (
    !device_enable && !$past(device_enable) |-> !conv_clk_tick)
    else $error("converter tick while powered down");
  a_latency_count: assert property (
    ($stable(output_latency) && $stable(fast_mode_select))[*2]
    |-> latency_mclk_count == lat_exp)
    else $error("latency count wrong");
  a_read_start: assert property (
    $fell(serial_data_out_oe_n) |-> $past(serial_load_strobe, 2))
    else $error("read-back started without strobe");
  a_read_bit_hold: assert property (
    !serial_data_out_oe_n && $changed(serial_data_out)
    |-> !sck && !$past(sck, 2))
    else $error("read-back bit moved outside low phase");
  a_write_on_strobe: assert property (
    $changed(offset_dac_red) |-> $past(serial_load_strobe, 2))
    else $error("register changed without strobe");
  c_read: cover property ($fell(serial_data_out_oe_n));
  c_fast_tick: cover property (conv_clk_tick && fast_mode_select);
  c_power_down: cover property ($fell(device_enable));
endmodule // acrb_props

bind acrb_reg_bank acrb_props acrb_props_inst (.mclk, .rst, .sck,
  .serial_load_strobe, .fast_mode_select, .serial_data_out,
  .serial_data_out_oe_n, .device_enable, .double_sampling_select,
  .external_clamp_reference, .clamp_reference_dac_en,
  .clamp_reference_pin_oe_n, .clamp_dac_span, .output_latency,
  .latency_mclk_count, .conv_clk_tick, .offset_dac_red);

// File: verif/acrb_ctrl_model.sv
`timescale 1ns/1ps
// Scanner controller on the serial port. The clock rests low between
// frames, and the data line flips after use so no stale bit looks valid.
module acrb_ctrl_model (
  input  wire mclk,                 // Bench clock.
  output reg  sck,                  // Serial clock, 160 ns in frames.
  output reg  serial_data_in,       // Serial data.
  output reg  serial_load_strobe,   // Load strobe.
  input  wire serial_data_out,      // Read-back data.
  input  wire serial_data_out_oe_n  // Read-back enable.
);
  // No pull on the shared pin, so a released pin is modelled as the
  // inverse of the last bit; a read taken after release then fails.
  wire sdo_pin;
  assign sdo_pin = serial_data_out_oe_n ? ~serial_data_out : serial_data_out;
  initial begin
    sck = 1'b0;
    serial_data_in = 1'b0;
    serial_load_strobe = 1'b0;
  end
  // Half a serial period.
  task half;
    repeat (8) @(posedge mclk);
  endtask
  // One bit, set up in the low phase and taken at the rise.
  task pulse(input logic b);
    @(posedge mclk);
    serial_data_in <= b;
    repeat (7) @(posedge mclk);
    sck <= 1'b1;
    half;
    sck <= 1'b0;
  endtask
  // Address then data, MSB first, then the load strobe.
  task send_frame(input logic [5:0] addr, input logic [7:0] data);
    logic [13:0] word;
    word = {addr, data};
    for (int i = 13; i >= 0; i--) pulse(word[i]);
    serial_data_in <= ~serial_data_in;
    half;
    serial_load_strobe <= 1'b1;
    half;
    serial_load_strobe <= 1'b0;
    half;
  endtask
  // Read frame; the MSB is taken after the strobe, each later bit late in the low phase after a fall.
  task read_reg(input logic [5:0] addr, output logic [7:0] data,
                output logic drove);
    send_frame(addr | 6'h10, 8'h00);
    drove = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      if (i < 7) pulse(~serial_data_in);
      repeat (6) @(negedge mclk);
      data[i] = sdo_pin;
      drove = drove & (serial_data_out_oe_n === 1'b0);
    end
    pulse(~serial_data_in);
    repeat (6) @(negedge mclk);
    drove = drove & (serial_data_out_oe_n === 1'b1);
  endtask
endmodule // acrb_ctrl_model

// File: verif/tb_acrb_reg_bank.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("mismatch at %0t got %h expected %h", $time, got, exp); \
  end \
end
module tb_acrb_reg_bank;
  localparam [7:0] REV = 8'h3c; // Arbitrary revision value.
  reg        mclk = 1'b0;
  reg        rst = 1'b1;
  reg        fast_mode_select = 1'b0;
  wire       sck, serial_data_in, serial_load_strobe;
  wire       serial_data_out, serial_data_out_oe_n, conv_clk_tick;
  wire       device_enable, double_sampling_select, max_speed_mode_flag;
  wire       output_polarity_invert, external_clamp_reference;
  wire       clamp_reference_dac_en, clamp_reference_pin_oe_n;
  wire       clamp_dac_span;
  wire [1:0] zero_input_output_offset, output_latency;
  wire [3:0] latency_mclk_count;
  wire [7:0] clamp_level_timing, clamp_colour_select, sample_pulse_detect;
  wire [7:0] test_control, offset_dac_red, offset_dac_green;
  wire [7:0] offset_dac_blue, amp_gain_red, amp_gain_green, amp_gain_blue;
  // Grouped views of the decoded fields, so each check fits one line.
  wire [4:0]  s1_flags = {device_enable, double_sampling_select,
    zero_input_output_offset, max_speed_mode_flag};
  wire [6:0]  s2_flags = {output_polarity_invert, external_clamp_reference,
    clamp_reference_dac_en, clamp_reference_pin_oe_n, clamp_dac_span,
    output_latency};
  wire [23:0] dac_rgb = {offset_dac_red, offset_dac_green, offset_dac_blue};
  wire [23:0] cfg_words = {clamp_level_timing, clamp_colour_select,
    sample_pulse_detect};
  int        errors = 0;
  int        n_compared = 0;
  logic [5:0] def_a [16] = '{6'h01, 6'h02, 6'h03, 6'h06, 6'h07, 6'h08,
    6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h20, 6'h21, 6'h22, 6'h23, 6'h28, 6'h2b};
  logic [7:0] def_v [16] = '{8'h0f, 8'h23, 8'h1f, 8'h05, REV, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00};
  logic [5:0] wr_a [10] = '{6'h01, 6'h02, 6'h03, 6'h06, 6'h08, 6'h09,
    6'h0a, 6'h07, 6'h23, 6'h2b};
  logic [7:0] wr_v [10] = '{8'h7f, 8'hef, 8'h3f, 8'h3d, 8'h1f, 8'h80,
    8'h00, REV, 8'h00, 8'h00};

  acrb_reg_bank #(.REVISION_CODE(REV)) acrb_reg_bank_inst (.mclk, .rst,
    .sck, .serial_data_in, .serial_load_strobe, .fast_mode_select,
    .serial_data_out, .serial_data_out_oe_n, .device_enable,
    .double_sampling_select, .zero_input_output_offset,
    .max_speed_mode_flag, .output_polarity_invert,
    .external_clamp_reference, .clamp_reference_dac_en,
    .clamp_reference_pin_oe_n, .clamp_dac_span, .output_latency,
    .latency_mclk_count, .conv_clk_tick, .clamp_level_timing,
    .clamp_colour_select, .sample_pulse_detect, .test_control,
    .offset_dac_red, .offset_dac_green, .offset_dac_blue, .amp_gain_red,
    .amp_gain_green, .amp_gain_blue);
  acrb_ctrl_model acrb_ctrl_model_inst (.mclk, .sck, .serial_data_in,
    .serial_load_strobe, .serial_data_out, .serial_data_out_oe_n);

  always #5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////
  // Port tasks; outputs are sampled at the falling edge, where settled.
  task wr(input logic [5:0] a, input logic [7:0] d);
    acrb_ctrl_model_inst.send_frame(a, d);
    @(negedge mclk);
  endtask
  task rd_chk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] got;
    logic       drove;
    acrb_ctrl_model_inst.read_reg(a, got, drove);
    `CHK(got, exp)
    `CHK(drove, 1'b1)
  endtask
  task chk_defaults;
    for (int i = 0; i < 16; i++) rd_chk(def_a[i], def_v[i]);
    `CHK({s1_flags, s2_flags}, {5'h18, 7'h14})
    `CHK(cfg_words, 24'h1f0500)
    `CHK({output_latency, test_control, amp_gain_blue}, 18'h0)
  endtask
  task report_and_stop;
    if (errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // A run that hangs ends here as a failure.
  initial begin
    repeat (90000) @(posedge mclk);
    errors++;
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    chk_defaults;
    // Fixed bits, reserved and read-only places, combined colour loads.
    for (int i = 0; i < 10; i++) begin
      wr(wr_a[i], (i == 8) ? 8'h5c : (i == 9) ? 8'hc3 : 8'hff);
      rd_chk(wr_a[i], wr_v[i]);
      if (i == 0)
        `CHK(s1_flags, 5'h1f)
      if (i == 1)
        `CHK(s2_flags, 7'h6f)
    end
    `CHK(dac_rgb, {3{8'h5c}})
    `CHK(cfg_words, 24'h3f3d1f)
    `CHK({amp_gain_red, amp_gain_green, amp_gain_blue}, {3{8'hc3}})
    rd_chk(6'h21, 8'h5c);
    // Every offset code, with the device powered down meanwhile.
    for (int k = 0; k < 4; k++) begin
      wr(6'h01, {2'h0, k[1:0], 4'h0});
      `CHK(s1_flags, {2'h0, k[1:0], 1'b0})
    end
    wr(6'h01, 8'h0f);
    // Every latency code in both converter period settings.
    for (int f = 0; f < 2; f++) begin
      for (int c = 0; c < 4; c++) begin
        @(posedge mclk);
        fast_mode_select <= f[0];
        wr(6'h02, {c[1:0], 6'h00});
        `CHK(latency_mclk_count, 4'(c * (f ? 3 : 2)))
        `CHK(s2_flags, {5'h04, c[1:0]})
      end
    end
    wr(6'h04, 8'h5a);
    chk_defaults;
    report_and_stop;
  end
endmodule // tb_acrb_reg_bank
